// ---- cecs_defs.svh ----
// constants for the cache event count select block: event selects, unit masks, widths, reset values
`ifndef CECS_DEFS_SVH
`define CECS_DEFS_SVH

// event select codes
`define CECS_SEL_DATA_REQ 8'h26
`define CECS_SEL_OWNERSHIP 8'h27
`define CECS_SEL_WRITEBACK 8'h28
`define CECS_SEL_LAST_LEVEL 8'h2E
`define CECS_SEL_ACTIVE 8'h3C

// unit masks with a fixed meaning
`define CECS_MASK_NONE 8'h00
`define CECS_MASK_LOW_I 8'h01
`define CECS_MASK_LOW_S 8'h02
`define CECS_MASK_LOW_M 8'h08
`define CECS_MASK_LOW_HIT 8'h0E
`define CECS_MASK_LOW_ALL 8'h0F
`define CECS_MASK_HIGH_I 8'h10
`define CECS_MASK_HIGH_S 8'h20
`define CECS_MASK_HIGH_E 8'h40
`define CECS_MASK_HIGH_M 8'h80
`define CECS_MASK_HIGH_HIT 8'hE0
`define CECS_MASK_HIGH_ALL 8'hF0
`define CECS_MASK_ALL 8'hFF
`define CECS_MASK_LLC_REF 8'h4F
`define CECS_MASK_LLC_MISS 8'h41

// source slots of the state matchers
`define CECS_SRC_N 5
`define CECS_SRC_DEMAND 0
`define CECS_SRC_PREFETCH 1
`define CECS_SRC_STORE_OWN 2
`define CECS_SRC_LOCK_OWN 3
`define CECS_SRC_WRITEBACK 4

// counter width and reset values
`define CECS_COUNT_W 48
`define CECS_INC_W 3
`define CECS_INC_RST 3'h0
`define CECS_HALT_RST 1'b0

`endif

// ---- cecs_pkg.sv ----
// types shared by the cache event count select block
package cecs_pkg;

	// line state of the target line; order gives the unit-mask bit within a nibble
	typedef enum logic [1:0] {
		CECS_LINE_I,
		CECS_LINE_S,
		CECS_LINE_E,
		CECS_LINE_M
	} cecs_line_e;

endpackage

// ---- cecs_state_match.sv ----
// one line-state matcher: a valid occurrence whose line state is picked by a mask nibble
`timescale 1ns/1ns

module cecs_state_match (
	input wire logic occ_valid,
	input wire cecs_pkg::cecs_line_e occ_state,
	input wire logic [3:0] state_mask,
	output logic hit
);

	// one-hot position of a line state inside a mask nibble
	function automatic logic [3:0] cecs_state_bit(input cecs_pkg::cecs_line_e st);
		logic [3:0] oh;
		oh = 4'h0;
		oh[st] = 1'b1;
		return oh;
	endfunction

	// any selected state bit matching counts the occurrence once
	assign hit = occ_valid & (|(state_mask & cecs_state_bit(occ_state)));

endmodule

// ---- cecs_halt_tracker.sv ----
// halt tracker: remembers whether the thread is halted and tells which cycles are active
`timescale 1ns/1ns
`include "cecs_defs.svh"

module cecs_halt_tracker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic halt_exec,
	input wire logic wake,
	output logic halted,
	output logic active
);

	typedef struct packed {
		logic halted;
	} cecs_halt_state_s;

	cecs_halt_state_s state;
	cecs_halt_state_s next_state;

	// halt wins over a wake in the same cycle so a halt is never lost
	always_comb begin
		next_state = state;
		if (halt_exec) begin
			next_state.halted = 1'b1;
		end else if (wake) begin
			next_state.halted = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= '{halted: `CECS_HALT_RST};
		end else begin
			state <= next_state;
		end
	end

	assign halted = state.halted;
	// the halt cycle itself is already not counted; the wake cycle counts again
	assign active = (~state.halted | wake) & ~halt_exec;

endmodule

// ---- cecs_counter_top.sv ----
// cache event count select: decodes event select and unit mask and counts qualifying occurrences
//
// Functional notes
// - 26H low nibble picks demand loads by state
// - 26H mask 80H counts modified prefetch loads
// - 26H mask F0H counts every prefetch request
// - 26H mask FFH counts demand plus prefetch
// - 27H mask 01H counts invalid store ownership
// - 27H 02H shared, 08H modified store ownership
// - 27H mask 0EH counts store ownership hits
// - 27H low nibble full counts all demand stores
// - store ownership counted is always demand only
// - 27H high nibble picks lock ownership state
// - 27H lock hit bits together count hits
// - 27H mask F0H counts every lock request
// - 28H low nibble picks writebacks by state
// - 28H mask 0FH counts every writeback
// - 2EH 4FH counts references, no prefetch fills
// - 2EH 41H counts misses, no prefetch fills
// - 3CH 00H counts each unhalted thread cycle
// - halt instruction stops the active cycle count
`timescale 1ns/1ns
`include "cecs_defs.svh"

module cecs_counter_top #(
	parameter int COUNT_W = `CECS_COUNT_W
) (
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic [7:0] EVENT_SEL,
	input wire logic [7:0] UNIT_MASK,
	input wire logic COUNT_ENABLE,
	input wire logic COUNT_CLEAR,
	input wire logic DEMAND_LOAD_VALID,
	input wire cecs_pkg::cecs_line_e DEMAND_LOAD_STATE,
	input wire logic PREFETCH_LOAD_VALID,
	input wire cecs_pkg::cecs_line_e PREFETCH_LOAD_STATE,
	input wire logic STORE_READ_FOR_OWNERSHIP_VALID,
	input wire logic STORE_READ_FOR_OWNERSHIP_PREFETCH,
	input wire cecs_pkg::cecs_line_e STORE_READ_FOR_OWNERSHIP_STATE,
	input wire logic LOCK_READ_FOR_OWNERSHIP_VALID,
	input wire cecs_pkg::cecs_line_e LOCK_READ_FOR_OWNERSHIP_STATE,
	input wire logic WRITEBACK_VALID,
	input wire cecs_pkg::cecs_line_e WRITEBACK_STATE,
	input wire logic LAST_LEVEL_REF_VALID,
	input wire logic LAST_LEVEL_REF_MISS,
	input wire logic LAST_LEVEL_REF_PREFETCH_FILL,
	input wire logic HALT_INSTRUCTION,
	input wire logic THREAD_WAKE,
	output logic [COUNT_W-1:0] EVENT_COUNT,
	output logic [`CECS_INC_W-1:0] LAST_INCREMENT,
	output logic EVENT_DEFINED,
	output logic THREAD_HALTED
);

	localparam int SRC_N = `CECS_SRC_N;

	typedef struct packed {
		logic [COUNT_W-1:0] count;
		logic [`CECS_INC_W-1:0] last_inc;
		logic defined;
	} cecs_top_state_s;

	cecs_top_state_s state;
	cecs_top_state_s next_state;

	logic [SRC_N-1:0] src_valid;
	cecs_pkg::cecs_line_e src_state [SRC_N];
	logic [3:0] src_mask [SRC_N];
	logic [SRC_N-1:0] src_hit;
	logic last_level_hit;
	logic active_hit;
	logic thread_active;
	logic thread_halted;
	logic sel_defined;
	logic [`CECS_INC_W-1:0] inc;

	// true when the select and mask pair names an event this block counts
	function automatic logic cecs_is_defined(input logic [7:0] sel, input logic [7:0] um);
		logic ok;
		ok = 1'b0;
		unique case (sel)
			`CECS_SEL_DATA_REQ: ok = (um != `CECS_MASK_NONE);
			`CECS_SEL_OWNERSHIP: ok = (um != `CECS_MASK_NONE);
			`CECS_SEL_WRITEBACK: ok = (um[3:0] != 4'h0) && (um[7:4] == 4'h0);
			`CECS_SEL_LAST_LEVEL: ok = (um == `CECS_MASK_LLC_REF) || (um == `CECS_MASK_LLC_MISS);
			`CECS_SEL_ACTIVE: ok = (um == `CECS_MASK_NONE);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	assign sel_defined = cecs_is_defined(EVENT_SEL, UNIT_MASK);

	// gather the state-qualified sources into slots for the matcher array
	assign src_valid[`CECS_SRC_DEMAND] = DEMAND_LOAD_VALID;
	assign src_valid[`CECS_SRC_PREFETCH] = PREFETCH_LOAD_VALID;
	// a prefetch-flagged ownership request is dropped: only demand ones count
	assign src_valid[`CECS_SRC_STORE_OWN] = STORE_READ_FOR_OWNERSHIP_VALID & ~STORE_READ_FOR_OWNERSHIP_PREFETCH;
	assign src_valid[`CECS_SRC_LOCK_OWN] = LOCK_READ_FOR_OWNERSHIP_VALID;
	assign src_valid[`CECS_SRC_WRITEBACK] = WRITEBACK_VALID;
	assign src_state[`CECS_SRC_DEMAND] = DEMAND_LOAD_STATE;
	assign src_state[`CECS_SRC_PREFETCH] = PREFETCH_LOAD_STATE;
	assign src_state[`CECS_SRC_STORE_OWN] = STORE_READ_FOR_OWNERSHIP_STATE;
	assign src_state[`CECS_SRC_LOCK_OWN] = LOCK_READ_FOR_OWNERSHIP_STATE;
	assign src_state[`CECS_SRC_WRITEBACK] = WRITEBACK_STATE;

	// route unit-mask nibbles to the sources that the event select picks
	always_comb begin
		for (int i = 0; i < SRC_N; i++) begin
			src_mask[i] = 4'h0;
		end
		unique case (EVENT_SEL)
			`CECS_SEL_DATA_REQ: begin
				src_mask[`CECS_SRC_DEMAND] = UNIT_MASK[3:0];
				src_mask[`CECS_SRC_PREFETCH] = UNIT_MASK[7:4];
			end
			`CECS_SEL_OWNERSHIP: begin
				src_mask[`CECS_SRC_STORE_OWN] = UNIT_MASK[3:0];
				src_mask[`CECS_SRC_LOCK_OWN] = UNIT_MASK[7:4];
			end
			`CECS_SEL_WRITEBACK: begin
				// an upper nibble here names nothing, so the whole pair stays silent
				if (UNIT_MASK[7:4] == 4'h0) begin
					src_mask[`CECS_SRC_WRITEBACK] = UNIT_MASK[3:0];
				end
			end
			default: begin
			end
		endcase
	end

	// one matcher per state-qualified source
	genvar g;
	generate
		for (g = 0; g < SRC_N; g++) begin : gen_match
			cecs_state_match u_match (
				.occ_valid(src_valid[g]),
				.occ_state(src_state[g]),
				.state_mask(src_mask[g]),
				.hit(src_hit[g])
			);
		end
	endgenerate

	// fills brought in by mid-level hardware prefetch never reach these two events
	always_comb begin
		last_level_hit = 1'b0;
		if (EVENT_SEL == `CECS_SEL_LAST_LEVEL && LAST_LEVEL_REF_VALID && !LAST_LEVEL_REF_PREFETCH_FILL) begin
			if (UNIT_MASK == `CECS_MASK_LLC_REF) begin
				last_level_hit = 1'b1;
			end else if (UNIT_MASK == `CECS_MASK_LLC_MISS) begin
				last_level_hit = LAST_LEVEL_REF_MISS;
			end
		end
	end

	cecs_halt_tracker u_halt (
		.clk(REF_CLK),
		.rst_n(RSTN),
		.halt_exec(HALT_INSTRUCTION),
		.wake(THREAD_WAKE),
		.halted(thread_halted),
		.active(thread_active)
	);

	// one per core clock; a throttled core clock simply slows this count
	assign active_hit = (EVENT_SEL == `CECS_SEL_ACTIVE) && (UNIT_MASK == `CECS_MASK_NONE) && thread_active;

	// sum of occurrences this cycle; at most two sources share one select
	always_comb begin
		inc = `CECS_INC_RST;
		for (int i = 0; i < SRC_N; i++) begin
			inc = `CECS_INC_W'(inc + `CECS_INC_W'(src_hit[i]));
		end
		inc = `CECS_INC_W'(inc + `CECS_INC_W'(last_level_hit) + `CECS_INC_W'(active_hit));
		if (!sel_defined) begin
			inc = `CECS_INC_RST;
		end
	end

	// clear beats enable; the counter wraps silently, overflow is handled elsewhere
	always_comb begin
		next_state = state;
		next_state.defined = sel_defined;
		next_state.last_inc = `CECS_INC_RST;
		if (COUNT_CLEAR) begin
			next_state.count = '0;
		end else if (COUNT_ENABLE) begin
			next_state.count = state.count + COUNT_W'(inc);
			next_state.last_inc = inc;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			state <= '{count: '0, last_inc: `CECS_INC_RST, defined: 1'b0};
		end else begin
			state <= next_state;
		end
	end

	assign EVENT_COUNT = state.count;
	assign LAST_INCREMENT = state.last_inc;
	assign EVENT_DEFINED = state.defined;
	assign THREAD_HALTED = thread_halted;

	// counter advances by exactly the amount it reports
	count_step_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		COUNT_ENABLE && !COUNT_CLEAR |=> EVENT_COUNT == COUNT_W'($past(EVENT_COUNT) + COUNT_W'(LAST_INCREMENT)))
		else $error("counter did not advance by the reported increment");

	count_hold_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		!COUNT_ENABLE && !COUNT_CLEAR |=> $stable(EVENT_COUNT) && LAST_INCREMENT == 3'h0)
		else $error("counter moved while disabled");

	undefined_zero_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		!cecs_is_defined(EVENT_SEL, UNIT_MASK) && !COUNT_CLEAR |=> LAST_INCREMENT == 3'h0 && !EVENT_DEFINED)
		else $error("undefined selection added to the counter");

	prefetch_mod_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		EVENT_SEL == `CECS_SEL_DATA_REQ && UNIT_MASK == `CECS_MASK_HIGH_M && COUNT_ENABLE && !COUNT_CLEAR
		|=> LAST_INCREMENT == 3'($past(PREFETCH_LOAD_VALID) && $past(PREFETCH_LOAD_STATE) == cecs_pkg::CECS_LINE_M))
		else $error("modified prefetch load count wrong");

	prefetch_any_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		EVENT_SEL == `CECS_SEL_DATA_REQ && UNIT_MASK == `CECS_MASK_HIGH_ALL && COUNT_ENABLE && !COUNT_CLEAR
		|=> LAST_INCREMENT == 3'($past(PREFETCH_LOAD_VALID)))
		else $error("all prefetch request count wrong");

	data_any_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		EVENT_SEL == `CECS_SEL_DATA_REQ && UNIT_MASK == `CECS_MASK_ALL && COUNT_ENABLE && !COUNT_CLEAR
		|=> LAST_INCREMENT == 3'(3'($past(DEMAND_LOAD_VALID)) + 3'($past(PREFETCH_LOAD_VALID))))
		else $error("all data request count wrong");

	demand_all_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		EVENT_SEL == `CECS_SEL_DATA_REQ && UNIT_MASK == `CECS_MASK_LOW_ALL && COUNT_ENABLE && !COUNT_CLEAR
		|=> LAST_INCREMENT == 3'($past(DEMAND_LOAD_VALID)))
		else $error("demand data request count wrong");

	store_miss_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		EVENT_SEL == `CECS_SEL_OWNERSHIP && UNIT_MASK == `CECS_MASK_LOW_I && COUNT_ENABLE && !COUNT_CLEAR
		|=> LAST_INCREMENT == 3'($past(STORE_READ_FOR_OWNERSHIP_VALID) && !$past(STORE_READ_FOR_OWNERSHIP_PREFETCH)
			&& $past(STORE_READ_FOR_OWNERSHIP_STATE) == cecs_pkg::CECS_LINE_I))
		else $error("store ownership miss count wrong");

	store_hit_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		EVENT_SEL == `CECS_SEL_OWNERSHIP && UNIT_MASK == `CECS_MASK_LOW_HIT && COUNT_ENABLE && !COUNT_CLEAR
		|=> LAST_INCREMENT == 3'($past(STORE_READ_FOR_OWNERSHIP_VALID) && !$past(STORE_READ_FOR_OWNERSHIP_PREFETCH)
			&& $past(STORE_READ_FOR_OWNERSHIP_STATE) != cecs_pkg::CECS_LINE_I))
		else $error("store ownership hit count wrong");

	store_shared_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		EVENT_SEL == `CECS_SEL_OWNERSHIP && UNIT_MASK == `CECS_MASK_LOW_S && COUNT_ENABLE && !COUNT_CLEAR
		|=> LAST_INCREMENT == 3'($past(STORE_READ_FOR_OWNERSHIP_VALID) && !$past(STORE_READ_FOR_OWNERSHIP_PREFETCH)
			&& $past(STORE_READ_FOR_OWNERSHIP_STATE) == cecs_pkg::CECS_LINE_S))
		else $error("store ownership shared count wrong");

	store_prefetch_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		EVENT_SEL == `CECS_SEL_OWNERSHIP && UNIT_MASK[7:4] == 4'h0 && STORE_READ_FOR_OWNERSHIP_PREFETCH && !COUNT_CLEAR
		|=> LAST_INCREMENT == 3'h0)
		else $error("prefetch ownership request was counted");

	lock_hit_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		EVENT_SEL == `CECS_SEL_OWNERSHIP && UNIT_MASK == `CECS_MASK_HIGH_HIT && COUNT_ENABLE && !COUNT_CLEAR
		|=> LAST_INCREMENT == 3'($past(LOCK_READ_FOR_OWNERSHIP_VALID)
			&& $past(LOCK_READ_FOR_OWNERSHIP_STATE) != cecs_pkg::CECS_LINE_I))
		else $error("lock ownership hit count wrong");

	lock_any_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		EVENT_SEL == `CECS_SEL_OWNERSHIP && UNIT_MASK == `CECS_MASK_HIGH_ALL && COUNT_ENABLE && !COUNT_CLEAR
		|=> LAST_INCREMENT == 3'($past(LOCK_READ_FOR_OWNERSHIP_VALID)))
		else $error("all lock ownership count wrong");

	writeback_any_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		EVENT_SEL == `CECS_SEL_WRITEBACK && UNIT_MASK == `CECS_MASK_LOW_ALL && COUNT_ENABLE && !COUNT_CLEAR
		|=> LAST_INCREMENT == 3'($past(WRITEBACK_VALID)))
		else $error("writeback count wrong");

	llc_miss_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		EVENT_SEL == `CECS_SEL_LAST_LEVEL && UNIT_MASK == `CECS_MASK_LLC_MISS && COUNT_ENABLE && !COUNT_CLEAR
		|=> LAST_INCREMENT == 3'($past(LAST_LEVEL_REF_VALID) && $past(LAST_LEVEL_REF_MISS)
			&& !$past(LAST_LEVEL_REF_PREFETCH_FILL)))
		else $error("last level miss count wrong");

	llc_ref_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		EVENT_SEL == `CECS_SEL_LAST_LEVEL && UNIT_MASK == `CECS_MASK_LLC_REF && COUNT_ENABLE && !COUNT_CLEAR
		|=> LAST_INCREMENT == 3'($past(LAST_LEVEL_REF_VALID) && !$past(LAST_LEVEL_REF_PREFETCH_FILL)))
		else $error("last level reference count wrong");

	active_cycle_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		EVENT_SEL == `CECS_SEL_ACTIVE && UNIT_MASK == `CECS_MASK_NONE && COUNT_ENABLE && !COUNT_CLEAR
		&& !THREAD_HALTED && !HALT_INSTRUCTION |=> LAST_INCREMENT == 3'h1)
		else $error("unhalted cycle not counted");

	halt_stop_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		HALT_INSTRUCTION && EVENT_SEL == `CECS_SEL_ACTIVE |=> THREAD_HALTED && LAST_INCREMENT == 3'h0)
		else $error("thread kept counting after halt");

	halt_hold_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		THREAD_HALTED && !THREAD_WAKE |=> THREAD_HALTED)
		else $error("halted thread left halt without a wake");

endmodule

// ---- cecs_event_source.sv ----
// event source model: cache hierarchy and thread pulses, launched on the falling edge
`timescale 1ns/1ns

module cecs_event_source (
	input wire logic clk,
	input wire logic [7:0] go,
	input wire logic [1:0] lo_state,
	input wire logic [1:0] hi_state,
	input wire logic store_pf,
	input wire logic llc_miss,
	input wire logic llc_fill,
	output logic dl_v = 1'b0,
	output cecs_pkg::cecs_line_e dl_s = cecs_pkg::CECS_LINE_I,
	output logic pf_v = 1'b0,
	output cecs_pkg::cecs_line_e pf_s = cecs_pkg::CECS_LINE_I,
	output logic st_v = 1'b0,
	output logic st_pf = 1'b0,
	output cecs_pkg::cecs_line_e st_s = cecs_pkg::CECS_LINE_I,
	output logic lk_v = 1'b0,
	output cecs_pkg::cecs_line_e lk_s = cecs_pkg::CECS_LINE_I,
	output logic wb_v = 1'b0,
	output cecs_pkg::cecs_line_e wb_s = cecs_pkg::CECS_LINE_I,
	output logic ll_v = 1'b0,
	output logic ll_miss = 1'b0,
	output logic ll_fill = 1'b0,
	output logic halt = 1'b0,
	output logic wake = 1'b0
);
	// one-cycle pulses; qualifiers outside a pulse flip, so a design reading them without valid is caught
	always @(negedge clk) begin
		dl_v <= go[0];
		dl_s <= go[0] ? cecs_pkg::cecs_line_e'(lo_state) : cecs_pkg::cecs_line_e'(~dl_s);
		pf_v <= go[1];
		pf_s <= go[1] ? cecs_pkg::cecs_line_e'(hi_state) : cecs_pkg::cecs_line_e'(~pf_s);
		st_v <= go[2];
		st_pf <= go[2] ? store_pf : ~st_pf;
		st_s <= go[2] ? cecs_pkg::cecs_line_e'(lo_state) : cecs_pkg::cecs_line_e'(~st_s);
		lk_v <= go[3];
		lk_s <= go[3] ? cecs_pkg::cecs_line_e'(hi_state) : cecs_pkg::cecs_line_e'(~lk_s);
		wb_v <= go[4];
		wb_s <= go[4] ? cecs_pkg::cecs_line_e'(lo_state) : cecs_pkg::cecs_line_e'(~wb_s);
		ll_v <= go[5];
		ll_miss <= go[5] ? llc_miss : ~ll_miss;
		ll_fill <= go[5] ? llc_fill : ~ll_fill;
		halt <= go[6];
		wake <= go[7];
	end
endmodule

// ---- test_cache_event_count_select.sv ----
// testbench: drives event sources through the model and checks the per-cycle count
`timescale 1ns/1ns
`include "cecs_defs.svh"

module test_cache_event_count_select;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] sel = 8'h00;
	logic [7:0] mask = 8'h00;
	logic en = 1'b0;
	logic clr = 1'b0;
	logic [7:0] go = 8'h00;
	logic [1:0] lo = 2'h0;
	logic [1:0] hi = 2'h0;
	logic spf = 1'b0;
	logic miss = 1'b0;
	logic fill = 1'b0;
	logic hold = 1'b0;
	logic halted_m = 1'b0;
	logic [`CECS_COUNT_W-1:0] cnt = 48'h0;
	logic dl_v, pf_v, st_v, st_pf, lk_v, wb_v, ll_v, ll_miss, ll_fill, halt, wake;
	cecs_pkg::cecs_line_e dl_s, pf_s, st_s, lk_s, wb_s;
	logic [`CECS_COUNT_W-1:0] event_count;
	logic [`CECS_INC_W-1:0] last_inc;
	logic ev_def;
	logic thr_halted;
	int n_errors = 0;
	int n_tests = 0;

	// 10 MHz core clock
	always #50 ref_clk = ~ref_clk;

	cecs_event_source src_u (.clk(ref_clk), .go(go), .lo_state(lo), .hi_state(hi), .store_pf(spf),
		.llc_miss(miss), .llc_fill(fill), .dl_v(dl_v), .dl_s(dl_s), .pf_v(pf_v), .pf_s(pf_s), .st_v(st_v),
		.st_pf(st_pf), .st_s(st_s), .lk_v(lk_v), .lk_s(lk_s), .wb_v(wb_v), .wb_s(wb_s), .ll_v(ll_v),
		.ll_miss(ll_miss), .ll_fill(ll_fill), .halt(halt), .wake(wake));

	cecs_counter_top #(.COUNT_W(`CECS_COUNT_W)) dut_u (.REF_CLK(ref_clk), .RSTN(rstn), .EVENT_SEL(sel),
		.UNIT_MASK(mask), .COUNT_ENABLE(en), .COUNT_CLEAR(clr), .DEMAND_LOAD_VALID(dl_v),
		.DEMAND_LOAD_STATE(dl_s), .PREFETCH_LOAD_VALID(pf_v), .PREFETCH_LOAD_STATE(pf_s),
		.STORE_READ_FOR_OWNERSHIP_VALID(st_v), .STORE_READ_FOR_OWNERSHIP_PREFETCH(st_pf),
		.STORE_READ_FOR_OWNERSHIP_STATE(st_s), .LOCK_READ_FOR_OWNERSHIP_VALID(lk_v),
		.LOCK_READ_FOR_OWNERSHIP_STATE(lk_s), .WRITEBACK_VALID(wb_v), .WRITEBACK_STATE(wb_s),
		.LAST_LEVEL_REF_VALID(ll_v), .LAST_LEVEL_REF_MISS(ll_miss), .LAST_LEVEL_REF_PREFETCH_FILL(ll_fill),
		.HALT_INSTRUCTION(halt), .THREAD_WAKE(wake), .EVENT_COUNT(event_count), .LAST_INCREMENT(last_inc),
		.EVENT_DEFINED(ev_def), .THREAD_HALTED(thr_halted));

	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// reference decode: {defined, occurrences} for the commanded sources of this cycle
	function automatic logic [3:0] model(input logic [7:0] s, input logic [7:0] m);
		logic [2:0] n;
		logic d;
		n = 3'h0;
		d = 1'b0;
		case (s)
			8'h26: begin
				d = (m != 8'h00);
				n = 3'(go[0] && m[lo]) + 3'(go[1] && m[4 + hi]);
			end
			8'h27: begin
				d = (m != 8'h00);
				n = 3'(go[2] && !spf && m[lo]) + 3'(go[3] && m[4 + hi]);
			end
			8'h28: begin
				d = (m[7:4] == 4'h0) && (m != 8'h00);
				n = 3'(d && go[4] && m[lo]);
			end
			8'h2E: begin
				d = (m == 8'h4F) || (m == 8'h41);
				n = 3'(d && go[5] && !fill && (m == 8'h4F || miss));
			end
			8'h3C: begin
				d = (m == 8'h00);
				n = 3'(d && !hold);
			end
			default: ;
		endcase
		return {d, n};
	endfunction

	// one cycle: select and mask at the falling edge, result checked just after the next rising edge
	task automatic run(input logic [7:0] s, input logic [7:0] m, input logic e_en = 1'b1, input logic e_clr = 1'b0);
		logic [3:0] e;
		logic [2:0] inc;
		hold = go[6] || (halted_m && !go[7]);
		e = model(s, m);
		inc = (e_clr || !e_en) ? 3'h0 : e[2:0];
		@(negedge ref_clk);
		sel = s;
		mask = m;
		en = e_en;
		clr = e_clr;
		@(posedge ref_clk);
		#1;
		cnt = e_clr ? 48'h0 : cnt + 48'(inc);
		check("increment", 48'(last_inc), 48'(inc));
		check("count", event_count, cnt);
		check("defined", 48'(ev_def), 48'(e[3]));
		check("halted", 48'(thr_halted), 48'(hold));
		halted_m = hold;
		go = 8'h00;
	endtask

	// every mask of the list against every line state, demand and prefetch states differing
	task automatic sweep(input logic [7:0] s, input logic [95:0] ml, input int n, input logic [7:0] g);
		for (int i = 0; i < n; i++) begin
			for (int st = 0; st < 4; st++) begin
				go = g;
				lo = 2'(st);
				hi = 2'(3 - st);
				miss = st[0];
				fill = st[1];
				run(s, ml[8*i +: 8]);
			end
		end
	endtask

	task automatic t_reset;
		repeat (3) @(posedge ref_clk);
		#1;
		check("reset count", event_count, 48'h0);
		check("reset defined", 48'(ev_def), 48'h0);
		check("reset halted", 48'(thr_halted), 48'h0);
		@(negedge ref_clk);
		rstn = 1'b1;
		// let the release edge pass before any source is commanded
		@(posedge ref_clk);
		#1;
		$display("test reset done");
	endtask

	// reset in mid-run while halted with a nonzero count: all outputs return to idle
	task automatic t_midreset;
		go = 8'h40;
		run(8'h3C, 8'h00);
		@(negedge ref_clk);
		rstn = 1'b0;
		en = 1'b0;
		@(posedge ref_clk);
		#1;
		cnt = 48'h0;
		halted_m = 1'b0;
		check("mid reset count", event_count, cnt);
		check("mid reset increment", 48'(last_inc), 48'h0);
		check("mid reset defined", 48'(ev_def), 48'h0);
		check("mid reset halted", 48'(thr_halted), 48'h0);
		@(negedge ref_clk);
		rstn = 1'b1;
		@(posedge ref_clk);
		#1;
		$display("test mid-run reset done");
	endtask

	task automatic t_cache;
		sweep(8'h26, {8'h01, 8'h02, 8'h04, 8'h08, 8'h0F, 8'h80, 8'hF0, 8'hFF, 8'h10, 8'h20, 8'h40, 8'hA5}, 12,
			8'h03);
		sweep(8'h27, {8'h01, 8'h02, 8'h08, 8'h0E, 8'h0F, 8'h10, 8'h20, 8'h40, 8'h80, 8'hE0, 8'hF0, 8'hFF}, 12,
			8'h0C);
		spf = 1'b1;
		sweep(8'h27, {88'h0, 8'h0F}, 1, 8'h04);
		spf = 1'b0;
		sweep(8'h28, {48'h0, 8'h01, 8'h02, 8'h04, 8'h08, 8'h0F, 8'h1F}, 6, 8'h10);
		sweep(8'h2E, {72'h0, 8'h4F, 8'h41, 8'h42}, 3, 8'h20);
		$display("test cache events done");
	endtask

	// halt/wake steps as pairs {wake, halt}: halt, idle halted, wake counts, both together halts
	task automatic t_active;
		logic [19:0] seq;
		seq = 20'h0_4232; // pairs from the top: 00 00 01 00 00 10 00 11 00 10
		for (int i = 9; i >= 0; i--) begin
			go = {seq[2*i +: 2], 6'b0};
			run(8'h3C, 8'h00);
		end
		run(8'h3C, 8'h01);
		$display("test active cycles done");
	endtask

	task automatic t_controls;
		go = 8'h03;
		run(8'h26, 8'hFF, 1'b0, 1'b0);
		go = 8'h03;
		run(8'h26, 8'hFF, 1'b1, 1'b1);
		go = 8'h03;
		run(8'h25, 8'hFF);
		go = 8'h03;
		run(8'h26, 8'hFF);
		$display("test controls done");
	endtask

	task automatic report_and_stop;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		t_reset;
		t_cache;
		t_active;
		t_midreset;
		t_controls;
		report_and_stop;
	end

	// the run needs about 160 cycles; over twelve times that means a hang
	initial begin
		repeat (2000) @(posedge ref_clk);
		n_errors++;
		report_and_stop;
	end
endmodule
